// ### design/stdtm_map.svh
`ifndef STDTM_MAP_SVH
`define STDTM_MAP_SVH

// register offsets on the byte port
`define STDTM_OFS_CTRL0 3'h0
`define STDTM_OFS_CTRL1 3'h1
`define STDTM_OFS_CNT_LO 3'h2
`define STDTM_OFS_CNT_HI 3'h3
`define STDTM_OFS_CMPA_LO 3'h4
`define STDTM_OFS_CMPA_HI 3'h5
`define STDTM_OFS_PERIOD 3'h6
`define STDTM_OFS_FLAGS 3'h7

// control byte 0 fields
`define STDTM_C0_PAUSE 7
`define STDTM_C0_CLK_HI 6
`define STDTM_C0_CLK_LO 4
`define STDTM_C0_EN 3

// control byte 1 fields
`define STDTM_C1_MODE_HI 7
`define STDTM_C1_MODE_LO 6
`define STDTM_C1_FN_HI 5
`define STDTM_C1_FN_LO 4
`define STDTM_C1_OC 3
`define STDTM_C1_POL 2
`define STDTM_C1_SWAP 1
`define STDTM_C1_CLR 0

// flag byte fields, write one to clear
`define STDTM_FL_A 0
`define STDTM_FL_P 1

// reset values
`define STDTM_RST_BYTE 8'h00
`define STDTM_RST_WORD 16'h0000

// clock source codes
`define STDTM_CK_SYS4 3'h0
`define STDTM_CK_SYS 3'h1
`define STDTM_CK_HI16 3'h2
`define STDTM_CK_HI64 3'h3
`define STDTM_CK_SUB0 3'h4
`define STDTM_CK_SUB1 3'h5
`define STDTM_CK_EXTR 3'h6
`define STDTM_CK_EXTF 3'h7

// prescaler terminal counts
`define STDTM_SYS4_LAST 2'h3
`define STDTM_HI16_LAST 4'hf
`define STDTM_HI64_LAST 6'h3f

// pin function codes
`define STDTM_FN_00 2'h0
`define STDTM_FN_01 2'h1
`define STDTM_FN_10 2'h2
`define STDTM_FN_11 2'h3

`endif

// ### design/stdtm_pkg.sv
package stdtm_pkg;

  typedef enum logic [1:0]
  {
    STDTM_MODE_CMP = 2'h0,
    STDTM_MODE_CAP = 2'h1,
    STDTM_MODE_PWM = 2'h2,
    STDTM_MODE_TMR = 2'h3
  } stdtm_mode_t;

  typedef struct packed
  {
    logic pause;
    logic [2:0] clkSrc;
    logic enable;
  } stdtm_ctrl0_t;

  typedef struct packed
  {
    stdtm_mode_t mode;
    logic [1:0] pinFn;
    logic outCtrl;
    logic polarity;
    logic swap;
    logic clrSel;
  } stdtm_ctrl1_t;

  typedef struct packed
  {
    logic p;
    logic a;
  } stdtm_flags_t;

endpackage

// ### design/stdtm_timer.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "stdtm_map.svh"

// How it works
// [RQ1] counter readable as two read-only bytes, low then high, zero at reset
// [RQ2] compare A held in two read/write bytes, zero at reset
// [RQ3] period byte compared with counter high byte, span value times 256
// [RQ4] period zero lets the counter wrap at its maximum
// [RQ5] clear-select low clears the counter on a period match
// [RQ6] mode 00 compare output, 11 timer, 10 with function 10 pwm
// [RQ7] compare mode, clear-select low: period match clears, both flags raised
// [RQ8] compare mode, clear-select high: A match clears, only A flag raised
// [RQ9] software must not write compare A zero in compare output mode
// [RQ10] compare A zero: wrap at ffff, no A flag
// [RQ11] compare mode pin changes only on an A match
// [RQ12] A match drives pin low, high, toggles or holds per function
// [RQ13] enable rising edge loads the pin with the initial level
// [RQ14] timer mode counts like compare mode but leaves the pin undriven
// [RQ15] pwm ignores clear-select; swap picks period and duty registers
// [RQ16] swap zero: period from period byte, duty from compare A
// [RQ17] swap one: period from compare A, duty from period byte span
// [RQ18] duty at or above period gives full duty
// [RQ19] pwm raises A flag on A match and P flag on P match
// [RQ20] pwm pin function passes waveform or forces inactive or active
// [RQ21] pwm counting and flags keep running while the pin is forced
// [RQ22] polarity bit inverts the pin level
// [RQ23] enable rise zeroes the counter; enable low freezes it
// [RQ24] pause holds the counter, release resumes from that value
// [RQ25] three-bit field selects the counter clock source
// [RQ26] compare function: 00 hold, 01 low, 10 high, 11 toggle
// [RQ27] counter steps by one per selected tick, compares use new value
// [RQ28] flags stay set until software clears them
module stdtm_timer
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic highClkTick,
  input wire logic subClkTick,
  input wire logic externalClockPin,
  output logic timerOutputPin,
  output logic timerOutputPinOe,
  output logic compareAFlag,
  output logic comparePFlag
);

  stdtm_pkg::stdtm_ctrl0_t ctrl0_r;
  stdtm_pkg::stdtm_ctrl1_t ctrl1_r;
  stdtm_pkg::stdtm_flags_t flags_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] compareA_r;
  logic [7:0] period_r;
  logic [7:0] rdata_r;
  logic [1:0] sysDiv_r;
  logic [5:0] hiDiv_r;
  logic extSync1_r;
  logic extSync2_r;
  logic extPrev_r;
  logic enPrev_r;
  logic pinState_r;
  logic pinOut_r;
  logic pinOe_r;
  logic tick;
  logic running;
  logic enRise;
  logic [15:0] countInc;
  logic matchA;
  logic matchP;
  logic clearCount;
  logic setA;
  logic setP;
  logic isPwm;
  logic [16:0] duty;
  logic pwmActive;
  logic pinLevel;

  // span of the period byte in counter clocks, zero means a full wrap
  function automatic logic [16:0] spanOf(input logic [7:0] rp);
    begin
      if (rp == 8'h00)
      begin
        spanOf = 17'h10000;
      end
      else
      begin
        spanOf = {1'b0, rp, 8'h00};
      end
    end
  endfunction

  function automatic logic wrHit(input logic [2:0] ofs, input logic [2:0] a,
                                 input logic wr);
    begin
      wrHit = wr && (a == ofs);
    end
  endfunction

  // prescalers run freely so a source switch needs no restart
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sysDiv_r <= 2'h0;
      hiDiv_r <= 6'h00;
    end
    else if (clkEn)
    begin
      sysDiv_r <= sysDiv_r + 2'h1;
      if (highClkTick)
      begin
        hiDiv_r <= hiDiv_r + 6'h01;
      end
    end
  end

  // external clock pin is asynchronous, two stages before the edge check
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extPrev_r <= 1'b0;
    end
    else if (clkEn)
    begin
      extSync1_r <= externalClockPin;
      extSync2_r <= extSync1_r;
      extPrev_r <= extSync2_r;
    end
  end

  always_comb
  begin
    tick = 1'b0;
    unique case (ctrl0_r.clkSrc) // [RQ25]
      `STDTM_CK_SYS4:
        tick = (sysDiv_r == `STDTM_SYS4_LAST);
      `STDTM_CK_SYS:
        tick = 1'b1;
      `STDTM_CK_HI16:
        tick = highClkTick && (hiDiv_r[3:0] == `STDTM_HI16_LAST);
      `STDTM_CK_HI64:
        tick = highClkTick && (hiDiv_r == `STDTM_HI64_LAST);
      `STDTM_CK_SUB0,
      `STDTM_CK_SUB1:
        tick = subClkTick;
      `STDTM_CK_EXTR:
        tick = extSync2_r && !extPrev_r;
      `STDTM_CK_EXTF:
        tick = !extSync2_r && extPrev_r;
    endcase
  end

  assign enRise = ctrl0_r.enable && !enPrev_r;
  // residual count must not match in the enable-rise cycle
  assign running = ctrl0_r.enable && !ctrl0_r.pause && tick // [RQ24]
                   && !enRise; // [RQ23]
  assign isPwm = (ctrl1_r.mode == stdtm_pkg::STDTM_MODE_PWM);
  assign countInc = count_r + 16'h0001; // [RQ27]

  // compare A zero never matches, so the counter wraps at ffff
  assign matchA = running && (compareA_r != `STDTM_RST_WORD)
                  && (countInc == compareA_r); // [RQ10]
  // high byte only; period zero matches at the natural wrap
  assign matchP = running && (countInc[15:8] == period_r)
                  && (countInc[7:0] == 8'h00); // [RQ3] [RQ4]

  always_comb
  begin
    clearCount = 1'b0;
    setA = 1'b0;
    setP = 1'b0;
    if (isPwm)
    begin
      // clear-select is ignored here
      clearCount = ctrl1_r.swap ? matchA : matchP; // [RQ15]
      setA = matchA; // [RQ19] [RQ21]
      setP = matchP; // [RQ19]
    end
    else if (ctrl1_r.clrSel)
    begin
      clearCount = matchA; // [RQ8]
      setA = matchA; // [RQ8]
      setP = 1'b0; // [RQ8]
    end
    else
    begin
      clearCount = matchP; // [RQ5] [RQ7]
      setA = matchA; // [RQ7]
      setP = matchP; // [RQ7] [RQ14]
    end
  end

  always_comb
  begin
    count_nxt = count_r;
    if (enRise)
    begin
      count_nxt = `STDTM_RST_WORD; // [RQ23]
    end
    else if (running)
    begin
      count_nxt = clearCount ? `STDTM_RST_WORD : countInc; // [RQ27]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      count_r <= `STDTM_RST_WORD; // [RQ1]
      enPrev_r <= 1'b0;
    end
    else if (clkEn)
    begin
      count_r <= count_nxt; // [RQ23] [RQ24]
      enPrev_r <= ctrl0_r.enable;
    end
  end

  // control and compare registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl0_r <= 5'(`STDTM_RST_BYTE);
      ctrl1_r <= `STDTM_RST_BYTE;
      compareA_r <= `STDTM_RST_WORD; // [RQ2]
      period_r <= `STDTM_RST_BYTE;
    end
    else if (clkEn)
    begin
      if (wrHit(`STDTM_OFS_CTRL0, regAddr, regWr))
      begin
        ctrl0_r <= regWdata[`STDTM_C0_PAUSE:`STDTM_C0_EN];
      end
      if (wrHit(`STDTM_OFS_CTRL1, regAddr, regWr))
      begin
        ctrl1_r <= regWdata;
      end
      // zero in compare output mode is a software fault, not trapped
      if (wrHit(`STDTM_OFS_CMPA_LO, regAddr, regWr))
      begin
        compareA_r[7:0] <= regWdata; // [RQ2] [RQ9]
      end
      if (wrHit(`STDTM_OFS_CMPA_HI, regAddr, regWr))
      begin
        compareA_r[15:8] <= regWdata; // [RQ2]
      end
      if (wrHit(`STDTM_OFS_PERIOD, regAddr, regWr))
      begin
        period_r <= regWdata;
      end
    end
  end

  // a match in the clearing cycle wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      flags_r <= 2'h0;
    end
    else if (clkEn)
    begin
      if (setA)
      begin
        flags_r.a <= 1'b1; // [RQ28]
      end
      else if (wrHit(`STDTM_OFS_FLAGS, regAddr, regWr)
               && regWdata[`STDTM_FL_A])
      begin
        flags_r.a <= 1'b0; // [RQ28]
      end
      if (setP)
      begin
        flags_r.p <= 1'b1; // [RQ28]
      end
      else if (wrHit(`STDTM_OFS_FLAGS, regAddr, regWr)
               && regWdata[`STDTM_FL_P])
      begin
        flags_r.p <= 1'b0; // [RQ28]
      end
    end
  end

  // compare output pin state, loaded at enable rise, else moved only by the A match
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pinState_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (enRise)
      begin
        pinState_r <= ctrl1_r.outCtrl; // [RQ13]
      end
      else if (setA && !isPwm) // [RQ11]
      begin
        unique case (ctrl1_r.pinFn) // [RQ12] [RQ26]
          `STDTM_FN_00:
            pinState_r <= pinState_r;
          `STDTM_FN_01:
            pinState_r <= 1'b0;
          `STDTM_FN_10:
            pinState_r <= 1'b1;
          `STDTM_FN_11:
            pinState_r <= !pinState_r;
        endcase
      end
    end
  end

  // pwm duty in counter clocks; 17 bits so a full wrap compares cleanly
  always_comb
  begin
    if (ctrl1_r.swap)
    begin
      duty = spanOf(period_r); // [RQ17]
    end
    else
    begin
      duty = {1'b0, compareA_r}; // [RQ16]
    end
  end

  // the counter never reaches the period, so duty >= period stays active
  assign pwmActive = ({1'b0, count_r} < duty); // [RQ18]

  always_comb
  begin
    pinLevel = pinState_r;
    if (isPwm)
    begin
      unique case (ctrl1_r.pinFn) // [RQ20]
        `STDTM_FN_00:
          pinLevel = !ctrl1_r.outCtrl;
        `STDTM_FN_01:
          pinLevel = ctrl1_r.outCtrl;
        `STDTM_FN_10:
          pinLevel = pwmActive ? ctrl1_r.outCtrl : !ctrl1_r.outCtrl;
        `STDTM_FN_11:
          pinLevel = !ctrl1_r.outCtrl;
      endcase
    end
  end

  // pin released in timer and capture modes
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pinOut_r <= 1'b0;
      pinOe_r <= 1'b0;
    end
    else if (clkEn)
    begin
      pinOut_r <= pinLevel ^ ctrl1_r.polarity; // [RQ22]
      pinOe_r <= (ctrl1_r.mode == stdtm_pkg::STDTM_MODE_CMP)
                 || isPwm; // [RQ6] [RQ14]
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rdata_r <= `STDTM_RST_BYTE;
    end
    else if (clkEn)
    begin
      rdata_r <= `STDTM_RST_BYTE;
      if (regRd)
      begin
        unique case (regAddr)
          `STDTM_OFS_CTRL0:
            rdata_r <= {ctrl0_r, 3'h0};
          `STDTM_OFS_CTRL1:
            rdata_r <= ctrl1_r;
          `STDTM_OFS_CNT_LO:
            rdata_r <= count_r[7:0]; // [RQ1]
          `STDTM_OFS_CNT_HI:
            rdata_r <= count_r[15:8]; // [RQ1]
          `STDTM_OFS_CMPA_LO:
            rdata_r <= compareA_r[7:0];
          `STDTM_OFS_CMPA_HI:
            rdata_r <= compareA_r[15:8];
          `STDTM_OFS_PERIOD:
            rdata_r <= period_r;
          `STDTM_OFS_FLAGS:
            rdata_r <= {6'h00, flags_r};
        endcase
      end
    end
  end

  assign regRdata = rdata_r;
  assign timerOutputPin = pinOut_r;
  assign timerOutputPinOe = pinOe_r;
  assign compareAFlag = flags_r.a;
  assign comparePFlag = flags_r.p;

endmodule

// ### verification/stdtm_timer_assertions.sv
`timescale 1ns/1ps
module stdtm_timer_chk
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic highClkTick,
  input wire logic subClkTick,
  input wire logic externalClockPin,
  input wire logic timerOutputPin,
  input wire logic timerOutputPinOe,
  input wire logic compareAFlag,
  input wire logic comparePFlag
);
  logic [7:0] c1_r;
  logic [15:0] cmpA_r;
  logic [7:0] per_r;
  logic [2:0] quiet_r;
  logic clrA;
  logic clrP;
  logic settled;
  assign clrA = regWr && regAddr == 3'h7 && regWdata[0];
  assign clrP = regWr && regAddr == 3'h7 && regWdata[1];
  // config only trusted once writes have rippled through the pin flops
  assign settled = quiet_r == 3'h7;
  always_ff @(posedge core_clk)
    if (srst)
    begin
      c1_r <= 8'h00;
      cmpA_r <= 16'h0000;
      per_r <= 8'h00;
    end
    else if (clkEn && regWr)
      case (regAddr)
        3'h1: c1_r <= regWdata;
        3'h4: cmpA_r[7:0] <= regWdata;
        3'h5: cmpA_r[15:8] <= regWdata;
        3'h6: per_r <= regWdata;
        default: ;
      endcase
  always_ff @(posedge core_clk)
    if (srst)
      quiet_r <= 3'h0;
    else if (clkEn && regWr && regAddr != 3'h7)
      quiet_r <= 3'h0;
    else if (clkEn && !settled)
      quiet_r <= quiet_r + 3'h1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_rd(logic [2:0] a);
    regRd && clkEn && regAddr == a;
  endsequence
  a_rdata_idle:
    assert property (clkEn && !regRd |=> regRdata == 8'h00)
      else $error("read data not idle");
  a_cmpa_back:
    assert property (s_rd(3'h4) |=> regRdata == cmpA_r[7:0])
      else $error("compare byte readback wrong");
  a_per_back:
    assert property (s_rd(3'h6) |=> regRdata == per_r)
      else $error("period byte readback wrong");
  a_flag_a_keep:
    assert property (compareAFlag && !clrA |=> compareAFlag)
      else $error("a flag dropped");
  a_flag_p_keep:
    assert property (comparePFlag && !clrP |=> comparePFlag)
      else $error("p flag dropped");
  a_tmr_no_oe:
    assert property (settled && c1_r[7:6] == 2'h3 |-> !timerOutputPinOe)
      else $error("pin driven in timer mode");
  a_cmp_hold:
    assert property (settled && c1_r[7:4] == 4'h0 |=>
      $stable(timerOutputPin)) else $error("pin moved with no change");
  a_clr_no_p:
    assert property (settled && c1_r[7:6] == 2'h0 && c1_r[0] &&
      !comparePFlag |=> !comparePFlag) else $error("p flag with a clear");
  a_zero_no_a:
    assert property (settled && c1_r[7:6] != 2'h2 && cmpA_r == 16'h0 &&
      !compareAFlag |=> !compareAFlag) else $error("a flag at zero");
endmodule

// ### verification/stdtm_load.sv
`timescale 1ns/1ps
// load on the output pin; counts cycles it is driven high
module stdtm_load
(
  input wire logic core_clk,
  input wire logic pin,
  input wire logic oe,
  input wire logic clr,
  output int highCnt
);
  always_ff @(posedge core_clk)
    if (clr)
      highCnt <= 0;
    else if (oe && pin)
      highCnt <= highCnt + 1;
endmodule

// ### verification/test_std_timer_compare_pwm.sv
`timescale 1ns/1ps
module test_std_timer_compare_pwm;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clkEn = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic highClkTick = 1'b0;
  logic subClkTick = 1'b0;
  logic externalClockPin = 1'b0;
  logic [7:0] regRdata;
  logic timerOutputPin;
  logic timerOutputPinOe;
  logic compareAFlag;
  logic comparePFlag;
  logic loadClr = 1'b0;
  int highCnt;
  logic [31:0] rnd = 32'hc60b;
  int n_mismatch = 0;
  int comparisons = 0;
  int model;
  int k;
  int i;
  logic [7:0] v;
  logic [15:0] got;
  logic oc;
  logic pol;
  logic e;
  // pwm table: ctrl1, compare a, window, expected high cycles
  logic [7:0] tC [6] = '{8'ha8, 8'ha8, 8'had, 8'haa, 8'h8a, 8'h9a};
  logic [15:0] tA [6] = '{16'h0040, 16'h0200, 16'h0040, 16'h0300,
    16'h0300, 16'h0300};
  int tW [6] = '{256, 256, 256, 768, 768, 768};
  int tH [6] = '{64, 256, 192, 256, 0, 768};
  always #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge core_clk)
  begin
    rnd <= lfsr(rnd);
    highClkTick <= rnd[3];
    subClkTick <= rnd[7];
    externalClockPin <= rnd[11];
  end
  stdtm_timer u_stdtm_timer
  (
    .core_clk, .srst, .clkEn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .highClkTick, .subClkTick, .externalClockPin,
    .timerOutputPin, .timerOutputPinOe, .compareAFlag, .comparePFlag
  );
  stdtm_load u_stdtm_load
  (
    .core_clk, .pin(timerOutputPin), .oe(timerOutputPinOe),
    .clr(loadClr), .highCnt
  );
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    // data stands only in the cycle after the strobe
    @(posedge core_clk);
    v = regRdata;
  endtask
  // two reads, so only meaningful while the counter is frozen
  task automatic rdcnt();
    rd(3'h2);
    got[7:0] = v;
    rd(3'h3);
    got[15:8] = v;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    $display("mismatch watchdog expected end seen hang");
    results();
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < 8; k++)
    begin
      rd(k[2:0]);
      chk("reset byte", {8'h00, v}, 16'h0000);
    end
    $display("test reset done");
    wr(3'h1, 8'hc0);
    for (k = 4; k < 7; k++)
    begin
      model = rnd[7:0];
      wr(k[2:0], model[7:0]);
      rd(k[2:0]);
      chk("rw byte", {8'h00, v}, model[15:0]);
    end
    wr(3'h2, 8'h5a);
    wr(3'h3, 8'ha5);
    rdcnt();
    chk("counter write", got, 16'h0000);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h00);
    clkEn <= 1'b0;
    wr(3'h6, 8'h55);
    clkEn <= 1'b1;
    rd(3'h6);
    chk("frozen write", {8'h00, v}, 16'h0000);
    $display("test registers done");
    wr(3'h0, 8'h18);
    k = 10 + rnd[6:0];
    repeat (k) @(posedge core_clk);
    wr(3'h0, 8'h98);
    model = k + 1;
    rdcnt();
    chk("count", got, model[15:0]);
    wr(3'h0, 8'h18);
    repeat (k) @(posedge core_clk);
    wr(3'h0, 8'h98);
    model = model + k + 2;
    rdcnt();
    chk("resumed count", got, model[15:0]);
    wr(3'h0, 8'h10);
    repeat (20) @(posedge core_clk);
    rdcnt();
    chk("stopped count", got, model[15:0]);
    wr(3'h0, 8'h98);
    rdcnt();
    chk("restart count", got, 16'h0000);
    for (k = 0; k < 8; k++)
    begin
      wr(3'h0, 8'h00);
      wr(3'h0, {1'b0, k[2:0], 4'h8});
      repeat (300) @(posedge core_clk);
      wr(3'h0, {1'b1, k[2:0], 4'h8});
      rdcnt();
      chk("source ticks", {15'h0, got != 16'h0}, 16'h1);
      if (k == 1)
        chk("sys ticks", got, 16'h012d);
    end
    chk("zero a flag", {15'h0, compareAFlag}, 16'h0);
    chk("timer oe", {15'h0, timerOutputPinOe}, 16'h0);
    $display("test counting done");
    wr(3'h5, 8'h03);
    wr(3'h6, 8'h01);
    // compare a stays nonzero in compare mode
    for (k = 0; k < 4; k++)
    begin
      oc = rnd[0];
      pol = rnd[1];
      wr(3'h0, 8'h00);
      wr(3'h1, {2'h0, k[1:0], oc, pol, 2'h1});
      wr(3'h7, 8'h03);
      wr(3'h0, 8'h18);
      repeat (400) @(posedge core_clk);
      chk("initial pin", {15'h0, timerOutputPin},
        {15'h0, oc ^ pol});
      for (i = 0; i < 1000 && compareAFlag !== 1'b1; i++)
        @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      e = (k == 0) ? oc : (k == 1) ? 1'b0 : (k == 2) ? 1'b1 : !oc;
      chk("match pin", {15'h0, timerOutputPin},
        {15'h0, e ^ pol});
      rd(3'h7);
      chk("cmp flags", {8'h00, v}, 16'h0001);
    end
    wr(3'h7, 8'h03);
    rd(3'h7);
    chk("cleared flags", {8'h00, v}, 16'h0000);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hc1);
    wr(3'h0, 8'h18);
    for (i = 0; i < 1000 && compareAFlag !== 1'b1; i++)
      @(posedge core_clk);
    rd(3'h7);
    chk("timer flags", {8'h00, v}, 16'h0001);
    chk("timer oe", {15'h0, timerOutputPinOe}, 16'h0);
    // clear-select low: period match clears, both flags in both modes
    for (k = 0; k < 2; k++)
    begin
      wr(3'h0, 8'h00);
      wr(3'h1, k[0] ? 8'hc0 : 8'h00);
      wr(3'h4, 8'h80);
      wr(3'h5, 8'h00);
      wr(3'h7, 8'h03);
      wr(3'h0, 8'h18);
      repeat (600) @(posedge core_clk);
      rd(3'h7);
      chk("clear p flags", {8'h00, v}, 16'h0003);
      chk("mode oe", {15'h0, timerOutputPinOe},
        {15'h0, !k[0]});
      wr(3'h0, 8'h98);
      rdcnt();
      chk("p clear count", got, 16'h005b);
    end
    $display("test compare done");
    for (k = 0; k < 6; k++)
    begin
      wr(3'h0, 8'h00);
      wr(3'h1, tC[k]);
      wr(3'h4, tA[k][7:0]);
      wr(3'h5, tA[k][15:8]);
      wr(3'h0, 8'h18);
      repeat (800) @(posedge core_clk);
      wr(3'h7, 8'h03);
      loadClr <= 1'b1;
      @(posedge core_clk);
      loadClr <= 1'b0;
      repeat (tW[k]) @(posedge core_clk);
      // one more edge so the last counted sample has landed
      @(posedge core_clk);
      chk("pwm high", highCnt[15:0],
        tH[k][15:0]);
      rd(3'h7);
      chk("pwm flags", {8'h00, v},
        {14'h0, 1'b1, tA[k] <= tW[k]});
    end
    $display("test pwm done");
    results();
  end
endmodule
bind stdtm_timer stdtm_timer_chk u_stdtm_timer_chk
(
  .core_clk, .srst, .clkEn, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .highClkTick, .subClkTick, .externalClockPin,
  .timerOutputPin, .timerOutputPinOe, .compareAFlag, .comparePFlag
);
